// *** gpio_port_pkg.sv ***
// shared constants, modes and carrier types of the gpio port controller
package gpio_port_pkg;

   localparam int PIN_COUNT = 16;

   // register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_DRIVE = 8'h04;
   localparam logic [7:0] OFS_SPEED = 8'h08;
   localparam logic [7:0] OFS_PULL = 8'h0c;
   localparam logic [7:0] OFS_LEVEL_IN = 8'h10;
   localparam logic [7:0] OFS_LEVEL_OUT = 8'h14;
   localparam logic [7:0] OFS_SET_RESET = 8'h18;
   localparam logic [7:0] OFS_FREEZE = 8'h1c;
   localparam logic [7:0] OFS_ALT_LO = 8'h20;
   localparam logic [7:0] OFS_ALT_HI = 8'h24;
   localparam logic [7:0] OFS_CLEAR = 8'h28;
   localparam logic [7:0] OFS_INVERT = 8'h2c;

   // reset values: the debug port carries its own straps
   localparam logic [31:0] MODE_RST_DEBUG = 32'h000a8280;
   localparam logic [31:0] SPEED_RST_DEBUG = 32'h000c0000;
   localparam logic [31:0] PULL_RST_DEBUG = 32'h00064040;
   localparam logic [31:0] MODE_RST = 32'h00000000;
   localparam logic [31:0] SPEED_RST = 32'h00000000;
   localparam logic [31:0] PULL_RST = 32'h00000000;
   localparam logic [31:0] DRIVE_RST = 32'h00000000;
   localparam logic [31:0] LEVEL_OUT_RST = 32'h00000000;
   localparam logic [31:0] ALT_RST = 32'h00000000;

   // field positions
   localparam int FREEZE_KEY_POS = 16;
   localparam int CLEAR_HALF_POS = 16;

   // ahb transfer encodings
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      MODE_INPUT = 2'b00,
      MODE_OUTPUT = 2'b01,
      MODE_ALT = 2'b10,
      MODE_ANALOG = 2'b11
   } pin_mode_t;

   typedef enum logic [1:0] {
      PULL_NONE = 2'b00,
      PULL_UP = 2'b01,
      PULL_DOWN = 2'b10,
      PULL_RSVD = 2'b11
   } pull_sel_t;

   // decoded speed class on the pad
   typedef enum logic [1:0] {
      SPEED_SLOW = 2'b00,
      SPEED_MID = 2'b01,
      SPEED_FAST = 2'b10
   } speed_class_t;

   typedef struct packed {
      pin_mode_t mode;
      logic open_drain;
      logic [1:0] speed;
      pull_sel_t pull;
   } pin_cfg_t;

   typedef struct packed {
      logic out;
      logic oe_n;
      logic pull_up;
      logic pull_down;
      logic schmitt_en;
      speed_class_t speed;
   } pad_ctl_t;

endpackage

// *** gpio_pin_pad.sv ***
// per-pin pad steering from mode, drive type, pull and speed
module gpio_pin_pad
   import gpio_port_pkg::*;
(
   input wire pin_cfg_t cfg,
   input wire logic level_out,
   input wire logic af_out,
   input wire logic af_oe,
   input wire logic add_en,
   input wire logic add_out,
   input wire logic add_oe_n,
   output pad_ctl_t ctl
);

   logic drive_val;
   logic drive_on;

   // source of the driver: output register or selected peripheral
   always_comb begin
      drive_val = level_out;
      drive_on = 1'b0;
      unique case (cfg.mode)
         MODE_INPUT: drive_on = 1'b0;
         MODE_OUTPUT: begin
            drive_val = level_out;
            drive_on = 1'b1;
         end
         MODE_ALT: begin
            drive_val = af_out;
            drive_on = af_oe;
         end
         MODE_ANALOG: drive_on = 1'b0;
      endcase
   end

   // pad controls; additional functions take priority over the mode
   always_comb begin
      ctl.out = 1'b0;
      ctl.oe_n = 1'b1;
      if (drive_on) begin
         if (cfg.open_drain) begin
            ctl.out = 1'b0;
            ctl.oe_n = drive_val;
         end else begin
            ctl.out = drive_val;
            ctl.oe_n = 1'b0;
         end
      end
      ctl.pull_up = (cfg.mode != MODE_ANALOG) && (cfg.pull == PULL_UP);
      ctl.pull_down = (cfg.mode != MODE_ANALOG) && (cfg.pull == PULL_DOWN);
      ctl.schmitt_en = (cfg.mode != MODE_ANALOG);
      ctl.speed = !cfg.speed[0] ? SPEED_SLOW : (cfg.speed[1] ? SPEED_FAST : SPEED_MID);
      if (add_en) begin
         ctl.out = add_out;
         ctl.oe_n = add_oe_n;
         ctl.pull_up = 1'b0;
         ctl.pull_down = 1'b0;
      end
   end

endmodule

// *** gpio_port_pin_control.sv ***
// sixteen-pin gpio port: ahb register file, pad steering, lock and atomic writes
// Functional notes
// - mode 00 input, 01 output, 10 alternate, 11 analog
// - pin y mode at bits 2y+1:2y
// - outputs obey per-pin drive type bit
// - drive bit 0 push-pull, 1 open-drain
// - open-drain: 0 pulls low, 1 releases
// - push-pull: 0 drives low, 1 high
// - pull 00 none, 01 up, 10 down
// - speed x0 slow, 01 middle, 11 fast
// - reset floating input, debug pins excepted
// - pad level sampled every clock unless analog
// - input mode: schmitt on, pull, no driver
// - output mode drives output register bit
// - output register reads written value, status reads pad
// - set, clear, toggle writes touch only ones
// - toggle inverts output within one cycle
// - analog: no pulls, driver, schmitt; status 0
// - alternate mode: peripheral drives, its enable steers
// - alternate mode picks one of sixteen functions
// - additional functions override standard pin settings
// - frozen pins ignore configuration writes until reset
// - byte, half, word access; debug port reset value
// - drive register upper half reserved, zero
module gpio_port_pin_control
   import gpio_port_pkg::*;
#(
   parameter bit DEBUG_PORT = 1'b0,
   parameter int NUM_PINS = PIN_COUNT
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe_n,
   output logic [NUM_PINS-1:0] pad_pull_up,
   output logic [NUM_PINS-1:0] pad_pull_down,
   output logic [NUM_PINS-1:0] pad_schmitt_en,
   output logic [2*NUM_PINS-1:0] pad_speed,
   input wire logic [16*NUM_PINS-1:0] af_out_bus,
   input wire logic [16*NUM_PINS-1:0] af_oe_bus,
   output logic [NUM_PINS-1:0] af_in,
   input wire logic [NUM_PINS-1:0] add_func_en,
   input wire logic [NUM_PINS-1:0] add_func_out,
   input wire logic [NUM_PINS-1:0] add_func_oe_n
);

   typedef enum logic [1:0] {
      FRZ_IDLE = 2'b00,
      FRZ_KEY1 = 2'b01,
      FRZ_KEY0 = 2'b10,
      FRZ_ARMED = 2'b11
   } freeze_state_t;

   localparam logic [31:0] MODE_INIT = DEBUG_PORT ? MODE_RST_DEBUG : MODE_RST;
   localparam logic [31:0] SPEED_INIT = DEBUG_PORT ? SPEED_RST_DEBUG : SPEED_RST;
   localparam logic [31:0] PULL_INIT = DEBUG_PORT ? PULL_RST_DEBUG : PULL_RST;

   // byte lanes of an ahb transfer
   function automatic logic [3:0] lanes_of(input logic [2:0] size, input logic [1:0] a);
      logic [3:0] l;
      l = 4'h0;
      unique case (size)
         HSIZE_BYTE: l = 4'h1 << a;
         HSIZE_HALF: l = a[1] ? 4'hc : 4'h3;
         default: l = 4'hf;
      endcase
      return l;
   endfunction

   // widen lanes to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] l);
      logic [31:0] m;
      m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
      return m;
   endfunction

   // per-pin mask widened to k bits per pin
   function automatic logic [31:0] spread(input logic [15:0] p, input int k, input int base);
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 32; i++) begin
         if ((i / k + base) < 16) begin
            m[i] = p[i / k + base];
         end
      end
      return m;
   endfunction

   // merge write data into a register under a mask
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [31:0] m);
      return (old & ~m) | (d & m);
   endfunction

   // register state
   logic [31:0] mode_r, mode_nxt;
   logic [15:0] drive_r, drive_nxt;
   logic [31:0] speed_r, speed_nxt;
   logic [31:0] pull_r, pull_nxt;
   logic [31:0] alt_lo_r, alt_lo_nxt;
   logic [31:0] alt_hi_r, alt_hi_nxt;
   logic [15:0] level_out_r, level_out_nxt;
   logic [15:0] level_in_r, level_in_nxt;
   logic [15:0] frozen_r, frozen_nxt;
   logic [15:0] frz_bits_r, frz_bits_nxt;
   logic frz_done_r, frz_done_nxt;
   freeze_state_t frz_state_r, frz_state_nxt;
   // bus data-phase state
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt;
   logic [3:0] wr_lanes_r, wr_lanes_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;

   logic addr_phase;
   logic rd_take;
   logic [31:0] wmask;
   logic [31:0] wdata;
   logic [31:0] mode_ok, speed_ok, pull_ok, alt_lo_ok, alt_hi_ok;
   logic [15:0] drive_ok;
   logic [15:0] analog_pins;
   logic [31:0] rd_sel;
   logic frz_wr;
   logic [15:0] frz_wr_bits;
   logic frz_wr_key;
   logic [7:0] haddr_w;
   logic frz_rd;

   assign addr_phase = hsel && hready && htrans[1];
   assign rd_take = addr_phase && !hwrite;
   // narrow reads share their word's offset in the read mux
   assign haddr_w = {haddr[7:2], 2'b00};
   assign wdata = hwdata;
   assign wmask = lane_mask(wr_lanes_r);
   // frozen pins drop out of every configuration mask
   assign mode_ok = wmask & ~spread(frozen_r, 2, 0);
   assign speed_ok = wmask & ~spread(frozen_r, 2, 0);
   assign pull_ok = wmask & ~spread(frozen_r, 2, 0);
   assign alt_lo_ok = wmask & ~spread(frozen_r, 4, 0);
   assign alt_hi_ok = wmask & ~spread(frozen_r, 4, 8);
   assign drive_ok = wmask[15:0] & ~frozen_r;
   assign frz_wr = wr_pend_r && (wr_addr_r == OFS_FREEZE) && !frz_done_r;
   assign frz_wr_bits = (frz_bits_r & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]);
   assign frz_wr_key = wmask[FREEZE_KEY_POS] ? wdata[FREEZE_KEY_POS] : 1'b0;
   assign frz_rd = rd_take && (haddr_w == OFS_FREEZE);

   // analog pins per mode field
   always_comb begin
      for (int p = 0; p < 16; p++) begin
         analog_pins[p] = (mode_r[2*p +: 2] == MODE_ANALOG);
      end
   end

   // configuration and output register next values
   always_comb begin
      mode_nxt = mode_r;
      drive_nxt = drive_r;
      speed_nxt = speed_r;
      pull_nxt = pull_r;
      alt_lo_nxt = alt_lo_r;
      alt_hi_nxt = alt_hi_r;
      level_out_nxt = level_out_r;
      if (wr_pend_r) begin
         unique case (wr_addr_r)
            OFS_MODE: mode_nxt = merge(mode_r, wdata, mode_ok);
            OFS_DRIVE: drive_nxt = (drive_r & ~drive_ok) | (wdata[15:0] & drive_ok);
            OFS_SPEED: speed_nxt = merge(speed_r, wdata, speed_ok);
            OFS_PULL: pull_nxt = merge(pull_r, wdata, pull_ok);
            OFS_ALT_LO: alt_lo_nxt = merge(alt_lo_r, wdata, alt_lo_ok);
            OFS_ALT_HI: alt_hi_nxt = merge(alt_hi_r, wdata, alt_hi_ok);
            OFS_LEVEL_OUT: level_out_nxt = (level_out_r & ~wmask[15:0])
                                           | (wdata[15:0] & wmask[15:0]);
            // set half wins over clear half for the same pin
            OFS_SET_RESET: level_out_nxt = (level_out_r
                                            & ~(wdata[31:16] & wmask[31:16]))
                                           | (wdata[15:0] & wmask[15:0]);
            OFS_CLEAR: level_out_nxt = level_out_r & ~(wdata[15:0] & wmask[15:0]);
            OFS_INVERT: level_out_nxt = level_out_r ^ (wdata[15:0] & wmask[15:0]);
            default: level_out_nxt = level_out_r;
         endcase
      end
   end

   // pad sampling, analog pins read zero
   always_comb begin
      level_in_nxt = pad_in & ~analog_pins;
   end

   // freeze key sequence: key 1, key 0, key 1 with the same pin bits, then a read
   always_comb begin
      frz_state_nxt = frz_state_r;
      frz_bits_nxt = frz_bits_r;
      frozen_nxt = frozen_r;
      frz_done_nxt = frz_done_r;
      if (frz_wr) begin
         frz_bits_nxt = frz_wr_bits;
         unique case (frz_state_r)
            FRZ_IDLE: frz_state_nxt = frz_wr_key ? FRZ_KEY1 : FRZ_IDLE;
            FRZ_KEY1: frz_state_nxt = (!frz_wr_key && frz_wr_bits == frz_bits_r)
                                      ? FRZ_KEY0 : FRZ_IDLE;
            FRZ_KEY0: frz_state_nxt = (frz_wr_key && frz_wr_bits == frz_bits_r)
                                      ? FRZ_ARMED : FRZ_IDLE;
            FRZ_ARMED: frz_state_nxt = FRZ_IDLE;
         endcase
      end else if (wr_pend_r && frz_state_r != FRZ_IDLE && wr_addr_r != OFS_FREEZE) begin
         // any other write between key steps aborts the sequence
         frz_state_nxt = FRZ_IDLE;
      end
      // the lock read may overlap the data phase of the last key write
      if (frz_rd && frz_state_nxt == FRZ_ARMED) begin
         frz_done_nxt = 1'b1;
         frozen_nxt = frz_bits_nxt;
      end
      // a key read before the third key step aborts the sequence
      if (frz_rd) begin
         frz_state_nxt = FRZ_IDLE;
      end
   end

   // read mux looks at next values so a read after a write sees it
   always_comb begin
      rd_sel = 32'h0;
      unique case (haddr_w)
         OFS_MODE: rd_sel = mode_nxt;
         OFS_DRIVE: rd_sel = {16'h0, drive_nxt};
         OFS_SPEED: rd_sel = speed_nxt;
         OFS_PULL: rd_sel = pull_nxt;
         OFS_LEVEL_IN: rd_sel = {16'h0, level_in_r};
         OFS_LEVEL_OUT: rd_sel = {16'h0, level_out_nxt};
         OFS_FREEZE: rd_sel = {15'h0, frz_done_nxt, frz_bits_nxt};
         OFS_ALT_LO: rd_sel = alt_lo_nxt;
         OFS_ALT_HI: rd_sel = alt_hi_nxt;
         default: rd_sel = 32'h0; // write-only and unmapped read zero
      endcase
   end

   // bus phase bookkeeping
   always_comb begin
      wr_pend_nxt = 1'b0;
      wr_addr_nxt = wr_addr_r;
      wr_lanes_nxt = wr_lanes_r;
      hrdata_nxt = hrdata_r;
      if (addr_phase) begin
         wr_pend_nxt = hwrite;
         wr_addr_nxt = {haddr[7:2], 2'b00};
         wr_lanes_nxt = lanes_of(hsize, haddr[1:0]);
         hrdata_nxt = hwrite ? 32'h0 : rd_sel;
      end
   end

   assign hrdata = hrdata_r;
   // zero wait states and never an error: every access completes at once
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // all register state
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= MODE_INIT;
         drive_r <= DRIVE_RST[15:0];
         speed_r <= SPEED_INIT;
         pull_r <= PULL_INIT;
         alt_lo_r <= ALT_RST;
         alt_hi_r <= ALT_RST;
         level_out_r <= LEVEL_OUT_RST[15:0];
         level_in_r <= 16'h0000;
         frozen_r <= 16'h0000;
         frz_bits_r <= 16'h0000;
         frz_done_r <= 1'b0;
         frz_state_r <= FRZ_IDLE;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_lanes_r <= 4'h0;
         hrdata_r <= 32'h00000000;
      end else begin
         mode_r <= mode_nxt;
         drive_r <= drive_nxt;
         speed_r <= speed_nxt;
         pull_r <= pull_nxt;
         alt_lo_r <= alt_lo_nxt;
         alt_hi_r <= alt_hi_nxt;
         level_out_r <= level_out_nxt;
         level_in_r <= level_in_nxt;
         frozen_r <= frozen_nxt;
         frz_bits_r <= frz_bits_nxt;
         frz_done_r <= frz_done_nxt;
         frz_state_r <= frz_state_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_lanes_r <= wr_lanes_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // event lines take af_in; software keeps such pins in input mode
   assign af_in = level_in_r;

   // one pad steering block per pin
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      pin_cfg_t cfg;
      pad_ctl_t ctl;
      logic [3:0] alt_sel;
      logic alt_o;
      logic alt_oe;

      assign alt_sel = (p < 8) ? alt_lo_r[4*(p % 8) +: 4] : alt_hi_r[4*(p % 8) +: 4];
      assign alt_o = af_out_bus[16*p + alt_sel];
      assign alt_oe = af_oe_bus[16*p + alt_sel];
      assign cfg.mode = pin_mode_t'(mode_r[2*p +: 2]);
      assign cfg.open_drain = drive_r[p];
      assign cfg.speed = speed_r[2*p +: 2];
      assign cfg.pull = pull_sel_t'(pull_r[2*p +: 2]);

      gpio_pin_pad u_pad (
         .cfg(cfg),
         .level_out(level_out_r[p]),
         .af_out(alt_o),
         .af_oe(alt_oe),
         .add_en(add_func_en[p]),
         .add_out(add_func_out[p]),
         .add_oe_n(add_func_oe_n[p]),
         .ctl(ctl)
      );

      assign pad_out[p] = ctl.out;
      assign pad_oe_n[p] = ctl.oe_n;
      assign pad_pull_up[p] = ctl.pull_up;
      assign pad_pull_down[p] = ctl.pull_down;
      assign pad_schmitt_en[p] = ctl.schmitt_en;
      assign pad_speed[2*p +: 2] = ctl.speed;
   end

endmodule

// *** gpio_port_properties.sv ***
// concurrent port checks of the gpio port controller
module gpio_port_properties
   import gpio_port_pkg::*;
#(
   parameter bit DEBUG_PORT = 1'b0,
   parameter int NUM_PINS = PIN_COUNT
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe_n,
   input wire logic [NUM_PINS-1:0] pad_pull_up,
   input wire logic [NUM_PINS-1:0] pad_pull_down,
   input wire logic [NUM_PINS-1:0] pad_schmitt_en,
   input wire logic [2*NUM_PINS-1:0] pad_speed,
   input wire logic [NUM_PINS-1:0] af_in,
   input wire logic [NUM_PINS-1:0] add_func_en,
   input wire logic [NUM_PINS-1:0] add_func_out,
   input wire logic [NUM_PINS-1:0] add_func_oe_n
);
   logic run_r;
   logic [NUM_PINS-1:0] spd_bad;
   logic [NUM_PINS-1:0] anl;
   // one cycle out of reset, so $past never sees reset-time pads
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         run_r <= 1'b0;
      end else begin
         run_r <= 1'b1;
      end
   end
   // the unused code 11 on the pad is the only illegal speed pair
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         spd_bad[i] = pad_speed[2*i] & pad_speed[2*i+1];
      end
   end
   // override pins excluded: their pad type is not ours to judge
   assign anl = ~pad_schmitt_en & ~add_func_en;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   sequence wr_addr;
      hsel && hready && htrans[1] && hwrite;
   endsequence
   sequence rd_drive;
      hsel && hready && htrans[1] && !hwrite && haddr == OFS_DRIVE;
   endsequence
   a_status_follows: assert property (run_r |->
      ((af_in ^ $past(pad_in)) & pad_schmitt_en & $past(pad_schmitt_en)) == '0)
      else $error("status bit does not follow pad level");
   a_analog_quiet: assert property (
      (anl & (~pad_oe_n | pad_pull_up | pad_pull_down)) == '0)
      else $error("analog pin has driver or pull");
   a_analog_zero: assert property (run_r |-> (anl & $past(anl) & af_in) == '0)
      else $error("analog pin status not zero");
   a_pull_exclusive: assert property ((pad_pull_up & pad_pull_down) == '0)
      else $error("pull-up and pull-down together");
   a_speed_legal: assert property (spd_bad == '0)
      else $error("illegal speed class");
   a_override_wins: assert property ((((pad_out ^ add_func_out)
      | (pad_oe_n ^ add_func_oe_n) | pad_pull_up | pad_pull_down) & add_func_en) == '0)
      else $error("additional function not in control");
   a_write_zero: assert property (wr_addr |=> hrdata == 32'h00000000)
      else $error("read data not zero after write");
   a_drive_upper: assert property (rd_drive |=> hrdata[31:16] == 16'h0000)
      else $error("drive register upper half not zero");
   a_reset_input: assert property ($fell(sys_rst) |->
      DEBUG_PORT || (pad_oe_n | add_func_en) == '1)
      else $error("pin driven after reset");
endmodule

bind gpio_port_pin_control gpio_port_properties #(.DEBUG_PORT(DEBUG_PORT), .NUM_PINS(NUM_PINS))
   i_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
   .pad_schmitt_en(pad_schmitt_en), .pad_speed(pad_speed), .af_in(af_in),
   .add_func_en(add_func_en), .add_func_out(add_func_out), .add_func_oe_n(add_func_oe_n));

// *** gpio_pad_env.sv ***
// external pad model: driver, pulls and an outside source resolve each pin
module gpio_pad_env
(
   input wire logic clk_sys,
   input wire logic [15:0] pad_out,
   input wire logic [15:0] pad_oe_n,
   input wire logic [15:0] pad_pull_up,
   input wire logic [15:0] pad_pull_down,
   input wire logic [15:0] ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] float_r = 16'h5555;
   // a floating pad wanders each cycle so a stale level never passes as driven
   always_ff @(posedge clk_sys) begin
      float_r <= ~float_r;
   end
   // outside source first, then our driver, then the weak pulls
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
         else if (pad_pull_up[i]) pad_in[i] = 1'b1;
         else if (pad_pull_down[i]) pad_in[i] = 1'b0;
         else pad_in[i] = float_r[i];
      end
   end
endmodule

// *** testbench.sv ***
// self-checking bench of the gpio port controller against the pad model
module testbench
   import gpio_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic hready = 1'b1;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata, rd, pad_speed;
   logic hreadyout, hresp;
   logic [15:0] pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down, pad_schmitt_en, af_in;
   logic [255:0] af_out_bus = 256'h0, af_oe_bus = 256'h0;
   logic [15:0] add_func_en = 16'h0000, add_func_out = 16'h0000, add_func_oe_n = 16'hffff;
   logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #5 clk_sys = ~clk_sys;

   gpio_port_pin_control i_gpio_port_pin_control (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up),
      .pad_pull_down(pad_pull_down), .pad_schmitt_en(pad_schmitt_en), .pad_speed(pad_speed),
      .af_out_bus(af_out_bus), .af_oe_bus(af_oe_bus), .af_in(af_in),
      .add_func_en(add_func_en), .add_func_out(add_func_out), .add_func_oe_n(add_func_oe_n));
   gpio_pad_env i_gpio_pad_env (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));

   task automatic complete_run();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one ahb transfer; entered just after an edge, read data taken at the data-phase edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] sz,
                      input logic [31:0] d);
      hsel = 1'b1;
      htrans = 2'h2;
      hwrite = wr;
      haddr = a;
      hsize = sz;
      @(posedge clk_sys);
      #1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwdata = d;
      @(posedge clk_sys);
      rd = hrdata;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, HSIZE_WORD, d);
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, HSIZE_WORD, 32'h00000000);
      check(what, rd, exp);
   endtask

   task automatic s_reset();
      logic [7:0] ofs [6] = '{OFS_MODE, OFS_DRIVE, OFS_SPEED, OFS_PULL, OFS_LEVEL_OUT, OFS_ALT_LO};
      check("reset oe_n", {16'h0000, pad_oe_n}, 32'h0000ffff);
      check("reset schmitt", {16'h0000, pad_schmitt_en}, 32'h0000ffff);
      check("bus ready", {30'h0, hreadyout, hresp}, 32'h00000002);
      for (int i = 0; i < 6; i++) begin
         rdchk("reset value", ofs[i], 32'h00000000);
      end
      wr(8'h30, 32'hffffffff);
      rdchk("unmapped", 8'h30, 32'h00000000);
      wr(OFS_DRIVE, 32'hffffffff);
      rdchk("drive reserved", OFS_DRIVE, 32'h0000ffff);
   endtask
   // pin0 push-pull, pin1 open-drain, pin2 analog with an outside high level
   task automatic s_output();
      ext_en = 16'h0084;
      ext_val = 16'h0084;
      wr(OFS_MODE, 32'h00000035);
      wr(OFS_DRIVE, 32'h00000002);
      wr(OFS_PULL, 32'h00000010);
      wr(OFS_LEVEL_OUT, 32'h00000003);
      check("drive high", {28'h0, pad_oe_n[2:0], pad_out[0]}, 32'h0000000d);
      check("analog pad", {29'h0, pad_schmitt_en[2], pad_pull_up[2], pad_oe_n[2]}, 32'h1);
      rdchk("level readback", OFS_LEVEL_OUT, 32'h00000003);
      bus(1'b0, OFS_LEVEL_IN, HSIZE_WORD, 32'h00000000);
      check("status", rd & 32'h00000005, 32'h00000001);
      wr(OFS_LEVEL_OUT, 32'h00000000);
      check("drive low", {28'h0, pad_oe_n[1:0], pad_out[1:0]}, 32'h00000000);
   endtask
   task automatic s_atomic();
      wr(OFS_SET_RESET, 32'h00010003);
      rdchk("set wins", OFS_LEVEL_OUT, 32'h00000003);
      wr(OFS_SET_RESET, 32'h00020000);
      rdchk("reset half", OFS_LEVEL_OUT, 32'h00000001);
      wr(OFS_CLEAR, 32'h00000001);
      rdchk("clear only", OFS_LEVEL_OUT, 32'h00000000);
      wr(OFS_INVERT, 32'h00000003);
      check("toggle next cycle", {30'h0, pad_oe_n[1], pad_out[0]}, 32'h00000003);
      rdchk("write-only port", OFS_INVERT, 32'h00000000);
   endtask
   // inputs 4..7: pull-up, pull-down, reserved pull, outside source; pin9 pull-up
   task automatic s_pull();
      wr(OFS_PULL, 32'h00043900);
      bus(1'b1, OFS_SPEED, HSIZE_HALF, 32'h00002d00);
      check("pull up", {29'h0, pad_pull_up[6:4]}, 32'h00000001);
      check("pull down", {29'h0, pad_pull_down[6:4]}, 32'h00000002);
      check("speed", {26'h0, pad_speed[13:8]}, 32'h00000009);
      check("input drivers off", {28'h0, pad_oe_n[7:4]}, 32'h0000000f);
      bus(1'b0, OFS_LEVEL_IN, HSIZE_WORD, 32'h00000000);
      check("input status", {29'h0, rd[7], rd[5], rd[4]}, 32'h00000005);
      check("af input", {29'h0, af_in[7], af_in[5], af_in[4]}, 32'h00000005);
      add_func_en = 16'h0200;
      add_func_out = 16'h0200;
      add_func_oe_n = 16'hfdff;
      @(posedge clk_sys);
      #1;
      check("override", {28'h0, pad_oe_n[9], pad_out[9], pad_pull_up[9], 1'b0}, 32'h4);
      add_func_en = 16'h0000;
   endtask
   // byte write sets pin8 alternate, function 3 routed
   task automatic s_alt();
      bus(1'b1, 8'h02, HSIZE_BYTE, 32'h00020000);
      rdchk("byte write", OFS_MODE, 32'h00020035);
      wr(OFS_ALT_HI, 32'h00000003);
      af_out_bus[131] = 1'b1;
      af_oe_bus[131] = 1'b1;
      @(posedge clk_sys);
      #1;
      check("alt drive", {30'h0, pad_oe_n[8], pad_out[8]}, 32'h00000001);
      af_oe_bus[131] = 1'b0;
      @(posedge clk_sys);
      #1;
      check("alt release", {31'h0, pad_oe_n[8]}, 32'h00000001);
   endtask
   // a wrong key on pin1 aborts; the proper sequence freezes pin0 only
   task automatic s_lock();
      wr(OFS_FREEZE, 32'h00010002);
      wr(OFS_FREEZE, 32'h00010002);
      wr(OFS_FREEZE, 32'h00010002);
      bus(1'b0, OFS_FREEZE, HSIZE_WORD, 32'h00000000);
      wr(OFS_FREEZE, 32'h00010001);
      wr(OFS_FREEZE, 32'h00000001);
      wr(OFS_FREEZE, 32'h00010001);
      bus(1'b0, OFS_FREEZE, HSIZE_WORD, 32'h00000000);
      check("key locked", {31'h0, rd[16]}, 32'h00000001);
      wr(OFS_MODE, 32'h00000000);
      rdchk("frozen field", OFS_MODE, 32'h00000001);
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      @(posedge clk_sys);
      #1;
      s_reset();
      s_output();
      s_atomic();
      s_pull();
      s_alt();
      s_lock();
      complete_run();
   end
endmodule
